// ==== src/ucs_top.v ====
// Serial channel with collision-checked bus mode and smart-card mode.
// Assumes control bits come straight from software-owned flops outside.
`timescale 1ns/1ps
`default_nettype none
`include "ucs_defines.vh"

// Small synchronous FIFO between the transmit buffer port and the shifter.
module ucs_fifo #(
  parameter WIDTH = 9,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1]; // Storage words.
  reg [AW-1:0]    wp_reg;          // Write pointer.
  reg [AW-1:0]    rp_reg;          // Read pointer.
  reg [AW:0]      cnt_reg;         // Occupancy.
  wire            push;
  wire            pop;
  assign in_ready  = (cnt_reg != DEPTH[AW:0]);
  assign out_valid = (cnt_reg != {(AW+1){1'b0}});
  assign out_data  = mem[rp_reg];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Pointer and count update; storage has no reset as it is qualified by count.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_reg  <= {AW{1'b0}};
      rp_reg  <= {AW{1'b0}};
      cnt_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wp_reg <= wp_reg + 1'b1;
      end
      if (pop) begin
        rp_reg <= rp_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end

  // Write port.
  always @(posedge clk) begin
    if (push) begin
      mem[wp_reg] <= in_data;
    end
  end
endmodule // ucs_fifo

module ucs_top #(
  parameter CHANNEL = 2
) (
  input  wire       CLOCK,
  input  wire       RSTN,
  input  wire [2:0] SERIAL_MODE_FIELD,
  input  wire       CLOCK_SOURCE_SEL,
  input  wire       INT_CLK_TICK,
  input  wire       EXT_CLK_PIN,
  input  wire [7:0] BAUD_DIVIDER,
  input  wire       TX_ENABLE_SET,
  input  wire       TX_ENABLE_CLR,
  output wire       TX_ENABLE,
  input  wire       RX_ENABLE,
  input  wire       PARITY_ENABLE,
  input  wire       PARITY_SENSE,
  input  wire       BIT_ORDER_SEL,
  input  wire       LOGIC_INVERSION,
  input  wire       ERROR_SIGNAL_ENABLE,
  input  wire       TX_IRQ_CAUSE_SEL,
  input  wire       CHAN0_COLLISION_ENABLE,
  input  wire       CHAN1_COLLISION_ENABLE,
  input  wire       COLLISION_SAMPLE_SEL,
  input  wire       COLLISION_AUTO_TX_OFF,
  input  wire       TX_START_TRIGGER_SEL,
  input  wire       ONESHOT_UNDERFLOW,
  input  wire [8:0] TX_BUFFER,
  input  wire       TX_BUFFER_VALID,
  output wire       TX_BUFFER_READY,
  output wire       TX_BUFFER_EMPTY,
  output reg  [8:0] RX_BUFFER,
  input  wire       RX_BUFFER_READ,
  output reg        RX_COMPLETE,
  output reg        OVERRUN_FLAG,
  output reg        FRAMING_FLAG,
  output reg        PARITY_ERROR_FLAG,
  output wire       ERROR_SUM,
  output reg        TX_IRQ,
  output reg        RX_IRQ,
  output reg        COLLISION_IRQ,
  output reg        TX_DATA_PIN,
  input  wire       RX_DATA_PIN
);
  localparam ST_IDLE  = 4'h1; // Transmitter idle.
  localparam ST_WAIT  = 4'h2; // Waiting for the start trigger.
  localparam ST_SHIFT = 4'h4; // Shifting a character out.
  localparam ST_DONE  = 4'h8; // Stop bit sent, awaiting bit-clock fall.
  wire bus_mode  = (SERIAL_MODE_FIELD == `UCS_MODE_BUS);
  wire card_mode = (SERIAL_MODE_FIELD == `UCS_MODE_CARD);
  wire nbits9    = bus_mode;                               // Bus bits carry nine data bits.
  wire par_on    = card_mode | (PARITY_ENABLE & ~bus_mode); // Card mode forces parity on.
  wire col_allow = (CHANNEL == 0) ? CHAN0_COLLISION_ENABLE :
                   (CHANNEL == 1) ? CHAN1_COLLISION_ENABLE : 1'b1;

  // Oversample tick: source clock divided by n+1; bit time is 16 of these.
  reg       ext_d_reg;    // Previous external clock level for edge detection.
  reg [7:0] div_reg;      // Baud divider counter.
  reg       tick_reg;     // One-cycle oversample tick.
  wire      src_tick = CLOCK_SOURCE_SEL ? (EXT_CLK_PIN & ~ext_d_reg) : INT_CLK_TICK;
  always @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      ext_d_reg <= 1'b0;
      div_reg   <= 8'h00;
      tick_reg  <= 1'b0;
    end else begin
      ext_d_reg <= EXT_CLK_PIN;
      tick_reg  <= 1'b0;
      if (src_tick) begin
        if (div_reg >= BAUD_DIVIDER) begin // A divider lowered on the fly must not wait for a wrap.
          div_reg  <= 8'h00;
          tick_reg <= 1'b1;
        end else begin
          div_reg <= div_reg + 8'h01;
        end
      end
    end
  end

  // Transmit path: the FIFO feeds the shifter and stalls the writer when full.
  wire [8:0] fifo_data;
  wire       fifo_valid;
  reg        fifo_pop;
  ucs_fifo #(.WIDTH(9), .DEPTH(`UCS_FIFO_DEPTH), .AW(2)) u_fifo (
    .clk       (CLOCK),
    .rst_n     (RSTN),
    .in_valid  (TX_BUFFER_VALID),
    .in_ready  (TX_BUFFER_READY),
    .in_data   (TX_BUFFER),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );
  assign TX_BUFFER_EMPTY = ~fifo_valid;

  reg        te_reg;      // Transmit enable, cleared by auto shutdown.
  reg [3:0]  tx_st_reg;   // Transmitter state, one-hot.
  reg [11:0] tx_sh_reg;   // Frame bits, sent from bit 0.
  reg [3:0]  tx_cnt_reg;  // Bits remaining.
  reg [3:0]  tx_ph_reg;   // Oversample phase within a bit.
  reg        rx_d_reg;    // Previous receive level.
  reg        guard_reg;   // Parity error signal being driven.
  reg [4:0]  guard_cnt_reg;
  wire       rx_rise = RX_DATA_PIN & ~rx_d_reg;
  wire       tx_ok   = te_reg & fifo_valid;
  assign TX_ENABLE = te_reg;

  // Build a frame: start, data in chosen order, optional parity, stop.
  function [11:0] build;
    input [8:0] d;
    input       nine;
    input       par;
    input       msb;
    input       inv;
    input       odd;
    reg   [8:0] o;
    reg         p;
    integer     i;
    begin
      o = d;
      for (i = 0; i < 8; i = i + 1) begin
        if (msb) begin
          o[i] = d[7-i];
        end
      end
      if (inv) begin
        o[7:0] = ~o[7:0];
      end
      p = ^d[7:0] ^ odd;
      if (inv) begin
        p = ~p;
      end
      if (nine) begin
        build = {2'b11, o, 1'b0};
      end else if (par) begin
        build = {2'b11, p, o[7:0], 1'b0};
      end else begin
        build = {3'b111, o[7:0], 1'b0};
      end
    end
  endfunction

  wire [3:0] frame_len = nbits9 ? 4'hB : (par_on ? 4'hB : 4'hA);
  wire       col_event = bus_mode & col_allow & (tx_st_reg == ST_SHIFT) &
                         (TX_DATA_PIN != RX_DATA_PIN) &
                         (COLLISION_SAMPLE_SEL ? ONESHOT_UNDERFLOW :
                          (tick_reg & (tx_ph_reg == `UCS_OVERSAMPLE_MID)));

  // Transmitter state machine.
  always @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      te_reg     <= 1'b0;
      tx_st_reg  <= ST_IDLE;
      tx_sh_reg  <= 12'hFFF;
      tx_cnt_reg <= 4'h0;
      tx_ph_reg  <= 4'h0;
      rx_d_reg   <= 1'b1;
      TX_IRQ     <= 1'b0;
      COLLISION_IRQ <= 1'b0;
      fifo_pop   <= 1'b0;
    end else begin
      rx_d_reg      <= RX_DATA_PIN;
      TX_IRQ        <= 1'b0;
      COLLISION_IRQ <= col_event;
      fifo_pop      <= 1'b0;
      // Software enable; the collision shutdown wins over a set in the same cycle.
      if (TX_ENABLE_SET) begin
        te_reg <= 1'b1;
      end
      if (TX_ENABLE_CLR | (col_event & COLLISION_AUTO_TX_OFF)) begin
        te_reg <= 1'b0;
      end
      case (tx_st_reg)
        ST_IDLE: begin
          if (tx_ok & (card_mode | bus_mode | 1'b1)) begin
            tx_st_reg <= ST_WAIT;
            tx_ph_reg <= 4'h0;
          end
        end
        ST_WAIT: begin
          // Trigger choice applies to bus mode; other modes wait one bit time.
          if (!tx_ok) begin
            tx_st_reg <= ST_IDLE;
          end else if (bus_mode & TX_START_TRIGGER_SEL ? rx_rise :
                       (tick_reg & (tx_ph_reg == 4'hF))) begin
            tx_sh_reg  <= build(fifo_data, nbits9, par_on, BIT_ORDER_SEL & card_mode,
                                LOGIC_INVERSION & card_mode, ~PARITY_SENSE);
            tx_cnt_reg <= frame_len;
            tx_ph_reg  <= 4'h0;
            fifo_pop   <= 1'b1;
            tx_st_reg  <= ST_SHIFT;
          end else if (tick_reg) begin
            tx_ph_reg <= tx_ph_reg + 4'h1;
          end
        end
        ST_SHIFT: begin
          if (tick_reg) begin
            tx_ph_reg <= tx_ph_reg + 4'h1;
            if (tx_ph_reg == 4'hF) begin
              tx_sh_reg  <= {1'b1, tx_sh_reg[11:1]};
              tx_cnt_reg <= tx_cnt_reg - 4'h1;
              if (tx_cnt_reg == 4'h1) begin
                tx_st_reg <= ST_DONE;
              end
            end
          end
        end
        ST_DONE: begin
          // The bit clock falls half a bit after the stop bit ends.
          if (tick_reg) begin
            tx_ph_reg <= tx_ph_reg + 4'h1;
            if (tx_ph_reg == `UCS_OVERSAMPLE_MID) begin
              TX_IRQ    <= TX_IRQ_CAUSE_SEL;
              tx_st_reg <= ST_IDLE;
            end
          end
        end
        default: tx_st_reg <= ST_IDLE;
      endcase
    end
  end

  // Receiver: start detection, mid-bit sampling, buffer load with flags.
  reg        rx_busy_reg;
  reg [3:0]  rx_ph_reg;
  reg [3:0]  rx_idx_reg;
  reg [10:0] rx_sh_reg;
  reg        unread_reg;  // Buffer holds a character not yet read.
  reg        ovr_pend_reg;
  reg        rx_armed_reg; // Line seen released since the last frame, so a held-low line cannot retrigger.
  wire [3:0] rx_len = frame_len - 4'h1; // Bits after the start bit.
  wire       smp    = tick_reg & (rx_ph_reg == `UCS_OVERSAMPLE_MID);
  reg  [8:0] rx_dat;
  reg        rx_perr;
  integer    k;
  // Decode the shifted frame into data and parity check.
  always @* begin
    rx_dat  = 9'h000;
    rx_perr = 1'b0;
    if (nbits9) begin
      rx_dat = rx_sh_reg[8:0];
    end else begin
      for (k = 0; k < 8; k = k + 1) begin
        rx_dat[k] = (BIT_ORDER_SEL & card_mode) ? rx_sh_reg[7-k] : rx_sh_reg[k];
      end
      if (LOGIC_INVERSION & card_mode) begin
        rx_dat[7:0] = ~rx_dat[7:0];
      end
      rx_perr = par_on & ((^rx_sh_reg[8:0] ^ (LOGIC_INVERSION & card_mode)) != ~PARITY_SENSE);
    end
  end

  always @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      rx_busy_reg  <= 1'b0;
      rx_ph_reg    <= 4'h0;
      rx_idx_reg   <= 4'h0;
      rx_sh_reg    <= 11'h000;
      unread_reg   <= 1'b0;
      ovr_pend_reg <= 1'b0;
      rx_armed_reg <= 1'b0;
      RX_BUFFER    <= 9'h000;
      RX_COMPLETE  <= 1'b0;
      RX_IRQ       <= 1'b0;
      OVERRUN_FLAG <= 1'b0;
      FRAMING_FLAG <= 1'b0;
      PARITY_ERROR_FLAG <= 1'b0;
      guard_reg    <= 1'b0;
      guard_cnt_reg <= 5'h00;
    end else begin
      RX_IRQ <= 1'b0;
      rx_armed_reg <= ~guard_reg & ~rx_busy_reg & (rx_armed_reg | RX_DATA_PIN);
      if (RX_BUFFER_READ) begin
        unread_reg   <= 1'b0;
        RX_COMPLETE  <= 1'b0;
        OVERRUN_FLAG <= 1'b0;
        if (guard_reg) begin
          PARITY_ERROR_FLAG <= 1'b0;
          guard_reg         <= 1'b0;
        end
      end
      if (guard_reg & tick_reg) begin
        guard_cnt_reg <= guard_cnt_reg - 5'h01;
        if (guard_cnt_reg == 5'h01) begin
          guard_reg <= 1'b0;
        end
      end
      if (!rx_busy_reg) begin
        if (RX_ENABLE & ~RX_DATA_PIN & tick_reg & rx_armed_reg) begin
          rx_busy_reg <= 1'b1;
          rx_ph_reg   <= 4'h1;
          rx_idx_reg  <= 4'h0;
        end
      end else if (tick_reg) begin
        rx_ph_reg <= rx_ph_reg + 4'h1;
        if (smp) begin
          if (rx_idx_reg == 4'h0 && RX_DATA_PIN) begin
            rx_busy_reg <= 1'b0; // False start.
          end else if (rx_idx_reg == rx_len) begin
            rx_busy_reg <= 1'b0;
            // Load the buffer; overrun leaves the receive flag alone.
            if (ovr_pend_reg) begin
              OVERRUN_FLAG <= 1'b1;
              RX_BUFFER    <= rx_dat;
            end else begin
              RX_BUFFER   <= rx_dat;
              RX_COMPLETE <= 1'b1;
              RX_IRQ      <= 1'b1;
              unread_reg  <= 1'b1;
            end
            FRAMING_FLAG      <= ~RX_DATA_PIN;
            PARITY_ERROR_FLAG <= rx_perr;
            if (rx_perr & card_mode & ERROR_SIGNAL_ENABLE) begin
              guard_reg     <= 1'b1;
              guard_cnt_reg <= `UCS_GUARD_TICKS;
            end
            ovr_pend_reg <= 1'b0;
          end else begin
            if (rx_idx_reg != 4'h0) begin
              rx_sh_reg[rx_idx_reg - 4'h1] <= RX_DATA_PIN;
            end
            if ((rx_idx_reg == rx_len - 4'h1) & unread_reg & ~RX_BUFFER_READ) begin
              ovr_pend_reg <= 1'b1;
            end
          end
          rx_idx_reg <= rx_idx_reg + 4'h1;
        end
      end
    end
  end

  assign ERROR_SUM = OVERRUN_FLAG | FRAMING_FLAG | PARITY_ERROR_FLAG;
  // Line driver: frame bit, forced low while the parity error signal runs.
  always @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      TX_DATA_PIN <= 1'b1;
    end else begin
      TX_DATA_PIN <= tx_sh_reg[0] & ~guard_reg;
    end
  end
endmodule // ucs_top
`default_nettype wire

// ==== src/ucs_defines.vh ====
// Constants for the collision-checked bus and smart-card serial channel.
// Assumes a single 200 MHz clock; all pins but the asynchronous reset RSTN are sampled synchronously.
`ifndef UCS_DEFINES_VH
`define UCS_DEFINES_VH
`define UCS_MODE_BUS        3'h6
`define UCS_MODE_CARD       3'h5
`define UCS_OVERSAMPLE      5'h10
`define UCS_OVERSAMPLE_MID  4'h7
`define UCS_DATA_BITS       4'h8
`define UCS_BUS_DATA_BITS   4'h9
`define UCS_FIFO_DEPTH      4
`define UCS_GUARD_TICKS     5'h10
`endif

// ==== verif/ucs_assertions.sv ====
// Checker for the serial channel: timing relations between its top ports.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
`include "ucs_defines.vh"
module ucs_chk (
  input wire logic       CLOCK,
  input wire logic       RSTN,
  input wire logic [2:0] SERIAL_MODE_FIELD,
  input wire logic       TX_ENABLE,
  input wire logic       RX_ENABLE,
  input wire logic       ERROR_SIGNAL_ENABLE,
  input wire logic       COLLISION_SAMPLE_SEL,
  input wire logic       COLLISION_AUTO_TX_OFF,
  input wire logic       ONESHOT_UNDERFLOW,
  input wire logic       TX_BUFFER_VALID,
  input wire logic       TX_BUFFER_READY,
  input wire logic       TX_BUFFER_EMPTY,
  input wire logic       RX_BUFFER_READ,
  input wire logic       OVERRUN_FLAG,
  input wire logic       FRAMING_FLAG,
  input wire logic       PARITY_ERROR_FLAG,
  input wire logic       ERROR_SUM,
  input wire logic       TX_IRQ,
  input wire logic       RX_IRQ,
  input wire logic       COLLISION_IRQ,
  input wire logic       TX_DATA_PIN
);
  // Every property samples on the clock and is quiet in reset.
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RSTN);
  AST_ERR_SUM: assert property (ERROR_SUM == (OVERRUN_FLAG | FRAMING_FLAG | PARITY_ERROR_FLAG))
    else $error("error summary differs from the error flags");
  AST_TX_IRQ_PULSE: assert property (TX_IRQ |=> !TX_IRQ)
    else $error("transmit irq longer than one cycle");
  AST_RX_IRQ_EN: assert property (RX_IRQ |-> RX_ENABLE ##1 !RX_IRQ)
    else $error("receive irq without enable or too long");
  AST_OVR_NO_RX_IRQ: assert property ($rose(OVERRUN_FLAG) |-> !RX_IRQ)
    else $error("receive irq raised with overrun");
  AST_COLL_BUS: assert property (COLLISION_IRQ |-> SERIAL_MODE_FIELD == `UCS_MODE_BUS)
    else $error("collision irq outside bus mode");
  AST_AUTO_OFF: assert property (COLLISION_IRQ && COLLISION_AUTO_TX_OFF |-> ##[0:1] !TX_ENABLE)
    else $error("transmit enable kept after collision");
  AST_SAMPLE_SEL: assert property (COLLISION_IRQ && COLLISION_SAMPLE_SEL |->
    $past(ONESHOT_UNDERFLOW) || $past(ONESHOT_UNDERFLOW, 2))
    else $error("collision judged without underflow");
  AST_NO_GUARD: assert property (SERIAL_MODE_FIELD == `UCS_MODE_CARD && !ERROR_SIGNAL_ENABLE && !TX_ENABLE
    && TX_BUFFER_EMPTY && TX_DATA_PIN |=> TX_DATA_PIN)
    else $error("transmit line pulled with error output off");
  AST_READ_RELEASE: assert property (RX_BUFFER_READ && PARITY_ERROR_FLAG && !TX_DATA_PIN && !TX_ENABLE
    |=> ##[0:1] TX_DATA_PIN && !PARITY_ERROR_FLAG)
    else $error("read did not release the error signal");
  AST_BUF_WRITE: assert property (TX_BUFFER_VALID && TX_BUFFER_READY |=> !TX_BUFFER_EMPTY)
    else $error("accepted word not shown as pending");
endmodule // ucs_chk
bind ucs_top ucs_chk chk (.CLOCK, .RSTN, .SERIAL_MODE_FIELD, .TX_ENABLE, .RX_ENABLE, .ERROR_SIGNAL_ENABLE,
  .COLLISION_SAMPLE_SEL, .COLLISION_AUTO_TX_OFF, .ONESHOT_UNDERFLOW, .TX_BUFFER_VALID, .TX_BUFFER_READY,
  .TX_BUFFER_EMPTY, .RX_BUFFER_READ, .OVERRUN_FLAG, .FRAMING_FLAG, .PARITY_ERROR_FLAG, .ERROR_SUM,
  .TX_IRQ, .RX_IRQ, .COLLISION_IRQ, .TX_DATA_PIN);
`default_nettype wire

// ==== verif/ucs_card.sv ====
// Card or bus node on the shared, pulled-up serial line.
// Assumes one bit lasts BIT clock cycles.
`timescale 1ns/1ps
`default_nettype none
module ucs_card #(
  parameter int BIT = 16
) (
  input  wire logic clk,
  input  wire logic tx_pin,
  output wire logic line
);
  logic drv = 1'b1; // Card output; low pulls the line.
  logic jam = 1'b0; // Holds the line low to provoke a collision.
  // Wired-AND with pull-up: any party pulling low wins.
  assign line = tx_pin & drv & ~jam;
  // Sends one direct-format character, LSB first with even parity.
  task automatic send(input logic [7:0] d, input logic bad_par, input logic bad_stop);
    logic [10:0] f;
    f = {~bad_stop, ^d ^ bad_par, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      drv = f[i];
      repeat (BIT) @(negedge clk);
    end
    drv = 1'b1;
  endtask
endmodule // ucs_card
`default_nettype wire

// ==== verif/tb.sv ====
// Self-checking bench for the serial channel in card and bus modes.
// Assumes a tick every clock, so divider 0 gives 16 cycles a bit.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic CLOCK = 0, RSTN = 0, CLOCK_SOURCE_SEL = 0, EXT_CLK_PIN = 0, TX_ENABLE_SET = 0, TX_ENABLE_CLR = 0;
  logic [2:0] SERIAL_MODE_FIELD = 3'h5;
  logic [7:0] BAUD_DIVIDER = 8'h00;
  logic RX_ENABLE = 0, PARITY_ENABLE = 1, PARITY_SENSE = 1, BIT_ORDER_SEL = 0, LOGIC_INVERSION = 0;
  logic ERROR_SIGNAL_ENABLE = 0, COLLISION_SAMPLE_SEL = 0, COLLISION_AUTO_TX_OFF = 0, TX_START_TRIGGER_SEL = 0;
  logic ONESHOT_UNDERFLOW = 0, TX_BUFFER_VALID = 0, RX_BUFFER_READ = 0, hit;
  logic [8:0] TX_BUFFER = 9'h000;
  wire logic TX_ENABLE, TX_BUFFER_READY, TX_BUFFER_EMPTY, RX_COMPLETE, OVERRUN_FLAG, FRAMING_FLAG;
  wire logic PARITY_ERROR_FLAG, ERROR_SUM, TX_IRQ, RX_IRQ, COLLISION_IRQ, TX_DATA_PIN, RX_DATA_PIN;
  wire logic [8:0] RX_BUFFER;
  int fails = 0, checks_done = 0, waited, rx_irqs = 0, coll_irqs = 0, n0;
  // Row: clock source, divider, inverse format, data, bit cycles, line bits from start to stop.
  typedef struct {logic src; logic [7:0] div; logic inv; logic [7:0] d; int bitc; logic [10:0] f;} ucs_row_t;
  ucs_row_t rows[4] = '{'{0, 8'h00, 0, 8'hA5, 16, 11'h54A}, '{0, 8'h01, 1, 8'h3C, 32, 11'h586},
                        '{1, 8'h00, 0, 8'h01, 32, 11'h602}, '{0, 8'h02, 1, 8'h80, 48, 11'h7FC}};
  always #2.5 CLOCK = ~CLOCK;
  // External clock runs at half the system rate.
  always @(negedge CLOCK) EXT_CLK_PIN <= ~EXT_CLK_PIN;
  // Interrupt pulses are counted so that none is missed between checks.
  always @(posedge CLOCK) begin
    if (RX_IRQ === 1'b1) rx_irqs++;
    if (COLLISION_IRQ === 1'b1) coll_irqs++;
  end
  ucs_top DUT (.CLOCK, .RSTN, .SERIAL_MODE_FIELD, .CLOCK_SOURCE_SEL, .INT_CLK_TICK(1'b1), .EXT_CLK_PIN,
    .BAUD_DIVIDER, .TX_ENABLE_SET, .TX_ENABLE_CLR, .TX_ENABLE, .RX_ENABLE, .PARITY_ENABLE, .PARITY_SENSE,
    .BIT_ORDER_SEL, .LOGIC_INVERSION, .ERROR_SIGNAL_ENABLE, .TX_IRQ_CAUSE_SEL(1'b1),
    .CHAN0_COLLISION_ENABLE(1'b0), .CHAN1_COLLISION_ENABLE(1'b0), .COLLISION_SAMPLE_SEL,
    .COLLISION_AUTO_TX_OFF, .TX_START_TRIGGER_SEL, .ONESHOT_UNDERFLOW, .TX_BUFFER, .TX_BUFFER_VALID,
    .TX_BUFFER_READY, .TX_BUFFER_EMPTY, .RX_BUFFER, .RX_BUFFER_READ, .RX_COMPLETE, .OVERRUN_FLAG,
    .FRAMING_FLAG, .PARITY_ERROR_FLAG, .ERROR_SUM, .TX_IRQ, .RX_IRQ, .COLLISION_IRQ, .TX_DATA_PIN, .RX_DATA_PIN);
  ucs_card #(.BIT(16)) card (.clk(CLOCK), .tx_pin(TX_DATA_PIN), .line(RX_DATA_PIN));
  task automatic chk(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1) begin
      fails++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask
  task automatic summarize;
    $display("checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Waits up to lim falling edges for a low line (0) or a transmit irq (1).
  task automatic wait_for(input logic which, input int lim);
    hit = 0;
    for (waited = 0; waited < lim && !hit; waited++) begin
      @(negedge CLOCK);
      hit = which ? TX_IRQ === 1'b1 : TX_DATA_PIN === 1'b0;
    end
  endtask
  // Offers a word and holds it until the edge that takes it.
  task automatic wr(input logic [8:0] d);
    TX_BUFFER = d;
    TX_BUFFER_VALID = 1;
    for (int i = 0; i < 20 && TX_BUFFER_READY !== 1'b1; i++) @(negedge CLOCK);
    @(negedge CLOCK);
    TX_BUFFER_VALID = 0;
  endtask
  task automatic te(input logic on);
    TX_ENABLE_SET = on;
    TX_ENABLE_CLR = !on;
    @(negedge CLOCK);
    TX_ENABLE_SET = 0;
    TX_ENABLE_CLR = 0;
  endtask
  task automatic rd;
    RX_BUFFER_READ = 1;
    @(negedge CLOCK);
    RX_BUFFER_READ = 0;
  endtask
  // Watchdog: the tests need some 5000 cycles.
  initial begin
    #(40000 * 5);
    fails++;
    summarize();
  end
  initial begin
    repeat (3) @(negedge CLOCK);
    RSTN = 1;
    @(negedge CLOCK);
    chk(TX_DATA_PIN === 1 && TX_BUFFER_EMPTY === 1 && TX_BUFFER_READY === 1 && ERROR_SUM === 0, "reset");
    chk(TX_IRQ === 0, "no stale transmit request after setup");
    te(1);
    foreach (rows[k]) begin
      CLOCK_SOURCE_SEL = rows[k].src;
      BAUD_DIVIDER = rows[k].div;
      PARITY_SENSE = !rows[k].inv;
      BIT_ORDER_SEL = rows[k].inv;
      LOGIC_INVERSION = rows[k].inv;
      wr({1'b0, rows[k].d});
      wait_for(0, 4 * rows[k].bitc);
      chk(hit && waited >= rows[k].bitc - 3 && waited <= rows[k].bitc + 6, "start delay");
      repeat (rows[k].bitc / 2 - 1) @(negedge CLOCK);
      for (int b = 0; b < 11; b++) begin
        chk(TX_DATA_PIN === rows[k].f[b], "frame bit");
        if (b < 10) repeat (rows[k].bitc) @(negedge CLOCK);
      end
      card.drv = !rows[k].inv; // The card refuses inverse rows by pulling the line from the middle of the stop bit.
      wait_for(1, 2 * rows[k].bitc);
      chk(hit, "transmit done irq");
      chk(RX_DATA_PIN === !rows[k].inv, "card error level at done");
      card.drv = 1;
    end
    $display("test formats ended");
    {CLOCK_SOURCE_SEL, BAUD_DIVIDER, PARITY_SENSE, BIT_ORDER_SEL, LOGIC_INVERSION} = 12'h004;
    te(0);
    RX_ENABLE = 1;
    card.send(8'h5A, 0, 0);
    chk(RX_BUFFER[7:0] === 8'h5A && RX_COMPLETE === 1 && ERROR_SUM === 0 && rx_irqs == 1, "receive");
    rd();
    // Inverse format: line byte 5A read MSB first and inverted is A5, and its parity is odd.
    {PARITY_SENSE, BIT_ORDER_SEL, LOGIC_INVERSION} = 3'h3;
    card.send(8'h5A, 0, 0);
    chk(RX_BUFFER[7:0] === 8'hA5 && PARITY_ERROR_FLAG === 0, "inverse receive");
    rd();
    {PARITY_SENSE, BIT_ORDER_SEL, LOGIC_INVERSION} = 3'h4;
    for (int en = 0; en < 2; en++) begin
      ERROR_SIGNAL_ENABLE = en[0];
      card.send(8'h5A, 1, 0);
      chk(PARITY_ERROR_FLAG === 1 && ERROR_SUM === 1, "parity flag");
      wait_for(0, 20);
      chk(hit === en[0], "error signal");
      rd();
      @(negedge CLOCK);
      chk(TX_DATA_PIN === 1 && (PARITY_ERROR_FLAG === 0 || !en), "release on read");
    end
    ERROR_SIGNAL_ENABLE = 0;
    repeat (400) @(negedge CLOCK);
    rd();
    card.send(8'h11, 0, 1);
    chk(FRAMING_FLAG === 1 && ERROR_SUM === 1, "framing");
    rd();
    n0 = rx_irqs;
    card.send(8'h01, 0, 0);
    card.send(8'h02, 0, 0);
    chk(OVERRUN_FLAG === 1 && rx_irqs == n0 + 1, "overrun");
    rd();
    $display("test receive ended");
    RX_ENABLE = 0;
    for (int i = 0; i < 4; i++) begin
      wr(9'h0F0 + 9'(i)); // A free edge between offers keeps each valid pulse apart.
      @(negedge CLOCK);
    end
    chk(TX_BUFFER_READY === 0 && TX_BUFFER_EMPTY === 0, "full buffer refuses");
    wait_for(0, 60);
    chk(!hit, "no start without enable");
    te(1);
    for (waited = 0; waited < 1200 && TX_BUFFER_EMPTY !== 1; waited++) @(negedge CLOCK);
    chk(TX_BUFFER_EMPTY === 1, "buffer drains");
    repeat (250) @(negedge CLOCK);
    $display("test buffer ended");
    // Bus mode: the far node jams the line so every high bit collides.
    {SERIAL_MODE_FIELD, PARITY_ENABLE, COLLISION_SAMPLE_SEL, COLLISION_AUTO_TX_OFF} = 6'h33;
    card.jam = 1;
    wr(9'h1FF);
    repeat (60) @(negedge CLOCK);
    chk(coll_irqs == 0, "no judgement before underflow");
    ONESHOT_UNDERFLOW = 1;
    @(negedge CLOCK);
    ONESHOT_UNDERFLOW = 0;
    repeat (4) @(negedge CLOCK);
    chk(coll_irqs == 1 && TX_ENABLE === 0, "collision at underflow, auto off");
    card.jam = 0;
    repeat (250) @(negedge CLOCK);
    {COLLISION_SAMPLE_SEL, COLLISION_AUTO_TX_OFF} = 2'h0;
    te(1);
    card.jam = 1;
    wr(9'h1FF);
    repeat (80) @(negedge CLOCK);
    chk(coll_irqs > 1 && TX_ENABLE === 1, "collision at sample point");
    card.jam = 0;
    repeat (250) @(negedge CLOCK);
    TX_START_TRIGGER_SEL = 1;
    card.jam = 1;
    wr(9'h1FF);
    wait_for(0, 60);
    chk(!hit, "held until receive rises");
    card.jam = 0;
    wait_for(0, 8);
    chk(hit, "start on receive rising edge");
    $display("test bus ended");
    summarize();
  end
endmodule // tb
`default_nettype wire
